// ===== hdl/cond_flag_bit_select.sv
// Condition flag register with update ports and branch condition evaluation
`timescale 1ns/1ps
module cond_flag_bit_select (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // Record-form completion
  input  wire logic        rec_valid_i,
  input  wire logic [31:0] rec_result_i,
  input  wire logic        fixed_point_exception_register_so_i,
  // Compare completion
  input  wire logic        cmp_valid_i,
  input  wire logic [2:0]  flag_group_operand_i,
  input  wire logic [31:0] first_source_gpr_i,
  input  wire logic [31:0] cmp_operand_i,
  input  wire logic        cmp_signed_i,
  // Move to flags register
  input  wire logic        mtf_valid_i,
  input  wire logic [7:0]  mtf_mask_i,
  input  wire logic [31:0] mtf_data_i,
  // Flag logical operation
  input  wire logic        flog_valid_i,
  input  wire logic [2:0]  flog_op_i,
  input  wire logic [4:0]  flog_src_a_i,
  input  wire logic [4:0]  flog_src_b_i,
  input  wire logic [4:0]  flog_dst_i,
  // Older writers still in flight, one bit per group
  input  wire logic [7:0]  flag_pend_grp_i,
  // Branch request
  input  wire logic        branch_valid_i,
  input  wire logic [4:0]  flag_index_field_i,
  input  wire logic [4:0]  branch_options_field_i,
  input  wire logic [31:0] loop_count_register_i,
  // Results
  output logic [31:0]      condition_flags_register_o,
  output logic             branch_busy_o,
  output logic             branch_done_o,
  output logic             branch_taken_o,
  output logic             branch_hint_o,
  output logic             tested_flag_o,
  output logic [5:0]       tested_flag_num_o,
  output logic             loop_count_we_o,
  output logic [31:0]      loop_count_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    cond_flag_pkg::branch_state_t st;
    logic [31:0]                  flags;
    logic [4:0]                   bi;
    logic [4:0]                   bo;
    logic [31:0]                  ctr;
    logic                         busy;
    logic                         done;
    logic                         taken;
    logic                         tested;
    logic [5:0]                   num;
    logic                         ctr_we;
    logic [31:0]                  ctr_out;
  } core_state_t;

  localparam core_state_t STATE_RST = '{
    st:      cond_flag_pkg::ST_IDLE,
    flags:   cond_flag_pkg::FLAGS_RST,
    bi:      cond_flag_pkg::FIELD_RST,
    bo:      cond_flag_pkg::FIELD_RST,
    ctr:     cond_flag_pkg::CTR_RST,
    busy:    1'b0,
    done:    1'b0,
    taken:   1'b0,
    tested:  1'b0,
    num:     cond_flag_pkg::NUM_RST,
    ctr_we:  1'b0,
    ctr_out: cond_flag_pkg::CTR_RST
  };

  core_state_t cur_ff;
  core_state_t nxt_st;

  logic             cmp_lt;
  logic             cmp_gt;
  logic             cmp_eq;
  logic             rec_neg;
  logic             rec_zero;
  logic             flog_a;
  logic             flog_b;
  logic             flog_bit;
  logic [31:0]      mtf_bits;
  logic [7:0][3:0]  grp_new;
  logic [7:0]       grp_hit;
  logic [2:0]       sel_group;
  logic [4:0]       sel_flat;
  logic [5:0]       sel_num;
  logic             sel_bit;
  logic             eval_ready;
  logic [31:0]      ctr_dec;
  logic             cond_ok;
  logic             ctr_ok;

  // ==========================================================================
  // Operand units
  flag_compare u_compare (
    .first_source_gpr_i (first_source_gpr_i),
    .other_operand_i    (cmp_operand_i),
    .signed_i           (cmp_signed_i),
    .lt_o               (cmp_lt),
    .gt_o               (cmp_gt),
    .eq_o               (cmp_eq)
  );

  flag_index_decode u_decode (
    .flag_index_field_i (cur_ff.bi),
    .group_o            (sel_group),
    .pos_o              (),
    .flat_o             (sel_flat),
    .flag_num_o         (sel_num)
  );

  assign rec_neg  = rec_result_i[31];
  assign rec_zero = rec_result_i == cond_flag_pkg::CTR_ZERO;
  assign flog_a   = cur_ff.flags[flog_src_a_i];
  assign flog_b   = cur_ff.flags[flog_src_b_i];

  always_comb
  begin
    case (cond_flag_pkg::flag_logic_op_t'(flog_op_i))
      cond_flag_pkg::LOG_AND:  flog_bit = flog_a & flog_b;
      cond_flag_pkg::LOG_OR:   flog_bit = flog_a | flog_b;
      cond_flag_pkg::LOG_XOR:  flog_bit = flog_a ^ flog_b;
      cond_flag_pkg::LOG_NAND: flog_bit = !(flog_a & flog_b);
      cond_flag_pkg::LOG_NOR:  flog_bit = !(flog_a | flog_b);
      cond_flag_pkg::LOG_EQV:  flog_bit = !(flog_a ^ flog_b);
      cond_flag_pkg::LOG_ANDC: flog_bit = flog_a & !flog_b;
      cond_flag_pkg::LOG_ORC:  flog_bit = flog_a | !flog_b;
      default:                 flog_bit = 1'b0;
    endcase
  end

  // ==========================================================================
  // Per-group update; later writers in this list override earlier ones
  for (genvar g = 0; g < cond_flag_pkg::GROUPS; g++)
  begin : g_grp
    logic [3:0] gn;
    logic       gh;

    assign mtf_bits[g*cond_flag_pkg::GROUP_BITS +: cond_flag_pkg::GROUP_BITS] = {4{mtf_mask_i[g]}};

    always_comb
    begin
      gn = cur_ff.flags[g*cond_flag_pkg::GROUP_BITS +: cond_flag_pkg::GROUP_BITS];
      gh = 1'b0;
      if (mtf_valid_i && mtf_mask_i[g])
      begin
        gn = mtf_data_i[g*cond_flag_pkg::GROUP_BITS +: cond_flag_pkg::GROUP_BITS];
        gh = 1'b1;
      end
      if (flog_valid_i && flog_dst_i[4:2] == 3'(g))
      begin
        gn[flog_dst_i[1:0]] = flog_bit;
        gh = 1'b1;
      end
      if (cmp_valid_i && flag_group_operand_i == 3'(g))
      begin
        gn[cond_flag_pkg::POS_LT] = cmp_lt;
        gn[cond_flag_pkg::POS_GT] = cmp_gt;
        gn[cond_flag_pkg::POS_EQ] = cmp_eq;
        gn[cond_flag_pkg::POS_SO] = fixed_point_exception_register_so_i;
        gh = 1'b1;
      end
      if (rec_valid_i && g == 0)
      begin
        gn[cond_flag_pkg::POS_LT] = rec_neg;
        gn[cond_flag_pkg::POS_GT] = !rec_neg && !rec_zero;
        gn[cond_flag_pkg::POS_EQ] = rec_zero;
        gn[cond_flag_pkg::POS_SO] = fixed_point_exception_register_so_i;
        gh = 1'b1;
      end
    end

    assign grp_new[g] = gn;
    assign grp_hit[g] = gh;
  end

  // ==========================================================================
  // Branch evaluation
  // A write landing this cycle is older than the branch, so wait one more
  assign eval_ready = !flag_pend_grp_i[sel_group] && !grp_hit[sel_group];
  assign sel_bit    = cur_ff.flags[sel_flat];
  assign ctr_dec    = cur_ff.ctr - cond_flag_pkg::CTR_ONE;
  assign cond_ok    = cur_ff.bo[cond_flag_pkg::BO_IGNORE] ||
                      (sel_bit == cur_ff.bo[cond_flag_pkg::BO_SENSE]);
  assign ctr_ok     = cur_ff.bo[cond_flag_pkg::BO_NO_DEC] ||
                      ((ctr_dec == cond_flag_pkg::CTR_ZERO) ==
                       cur_ff.bo[cond_flag_pkg::BO_ZERO]);

  always_comb
  begin
    nxt_st        = cur_ff;
    nxt_st.flags  = grp_new;
    nxt_st.done   = 1'b0;
    nxt_st.ctr_we = 1'b0;
    case (cur_ff.st)
      cond_flag_pkg::ST_IDLE:
      begin
        if (branch_valid_i)
        begin
          nxt_st.st   = cond_flag_pkg::ST_HOLD;
          nxt_st.busy = 1'b1;
          nxt_st.bi   = flag_index_field_i;
          nxt_st.bo   = branch_options_field_i;
          nxt_st.ctr  = loop_count_register_i;
        end
      end
      cond_flag_pkg::ST_HOLD:
      begin
        if (eval_ready)
        begin
          nxt_st.st      = cond_flag_pkg::ST_IDLE;
          nxt_st.busy    = 1'b0;
          nxt_st.done    = 1'b1;
          nxt_st.tested  = sel_bit;
          nxt_st.num     = sel_num;
          nxt_st.taken   = cond_ok && ctr_ok;
          nxt_st.ctr_we  = !cur_ff.bo[cond_flag_pkg::BO_NO_DEC];
          nxt_st.ctr_out = cur_ff.bo[cond_flag_pkg::BO_NO_DEC] ? cur_ff.ctr : ctr_dec;
        end
      end
      default:
      begin
        nxt_st.st   = cond_flag_pkg::ST_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      cur_ff <= STATE_RST;
    else
      cur_ff <= nxt_st;
  end

  // ==========================================================================
  // Outputs
  assign condition_flags_register_o = cur_ff.flags;
  assign branch_busy_o              = cur_ff.busy;
  assign branch_done_o              = cur_ff.done;
  assign branch_taken_o             = cur_ff.taken;
  assign branch_hint_o              = cur_ff.bo[cond_flag_pkg::BO_HINT];
  assign tested_flag_o              = cur_ff.tested;
  assign tested_flag_num_o          = cur_ff.num;
  assign loop_count_we_o            = cur_ff.ctr_we;
  assign loop_count_o               = cur_ff.ctr_out;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  flag_number_a: assert property (
    branch_done_o |-> tested_flag_num_o ==
      cond_flag_pkg::FLAG_BASE + 6'({cur_ff.bi[4:2], 2'h0}) + 6'(cur_ff.bi[1:0]))
    else $error("tested flag number wrong");

  record_lt_a: assert property (
    rec_valid_i |=> condition_flags_register_o[cond_flag_pkg::POS_LT] == $past(rec_neg))
    else $error("record less-than flag wrong");

  record_gt_a: assert property (
    rec_valid_i && !rec_neg && !rec_zero |=> condition_flags_register_o[cond_flag_pkg::POS_GT])
    else $error("record greater-than flag not set");

  record_eq_a: assert property (
    rec_valid_i |=> condition_flags_register_o[cond_flag_pkg::POS_EQ] == $past(rec_zero))
    else $error("record same-value flag wrong");

  record_so_a: assert property (
    rec_valid_i |=> condition_flags_register_o[cond_flag_pkg::POS_SO] ==
      $past(fixed_point_exception_register_so_i))
    else $error("record summary overflow wrong");

  compare_set_a: assert property (
    cmp_valid_i && !(rec_valid_i && flag_group_operand_i == 3'h0) |=>
      condition_flags_register_o[{$past(flag_group_operand_i), 2'h0} +: 3] ==
      $past({cmp_eq, cmp_gt, cmp_lt}))
    else $error("compare flags wrong");

  move_write_a: assert property (
    mtf_valid_i && !rec_valid_i && !cmp_valid_i && !flog_valid_i |=>
      ((condition_flags_register_o ^ $past(mtf_data_i)) & $past(mtf_bits)) == 32'h0)
    else $error("move to flags not written");

  pend_stall_a: assert property (
    cur_ff.st == cond_flag_pkg::ST_HOLD && flag_pend_grp_i[sel_group] |=>
      !branch_done_o && branch_busy_o)
    else $error("branch evaluated with older writer pending");

  cond_sense_a: assert property (
    branch_done_o && !cur_ff.bo[cond_flag_pkg::BO_IGNORE] &&
      cur_ff.bo[cond_flag_pkg::BO_NO_DEC] |-> branch_taken_o ==
      (tested_flag_o == cur_ff.bo[cond_flag_pkg::BO_SENSE]))
    else $error("condition sense wrong");

  count_dec_a: assert property (
    branch_done_o && !cur_ff.bo[cond_flag_pkg::BO_NO_DEC] |->
      loop_count_we_o && loop_count_o == cur_ff.ctr - cond_flag_pkg::CTR_ONE)
    else $error("loop count not decremented");

  done_pulse_a: assert property (
    branch_done_o |=> !branch_done_o)
    else $error("done longer than one cycle");

endmodule

// ===== hdl/cond_flag_pkg.sv
// Shared constants and types of the condition flag select and update logic
package cond_flag_pkg;

  // ==========================================================================
  // Flag register geometry
  localparam int          GROUPS      = 8;
  localparam int          GROUP_BITS  = 4;
  localparam int          FLAG_COUNT  = 32;
  localparam logic [5:0]  FLAG_BASE   = 6'h20;

  // ==========================================================================
  // Position of each flag inside a group
  localparam logic [1:0]  POS_LT      = 2'h0;
  localparam logic [1:0]  POS_GT      = 2'h1;
  localparam logic [1:0]  POS_EQ      = 2'h2;
  localparam logic [1:0]  POS_SO      = 2'h3;

  // ==========================================================================
  // Branch options field, printed bit 0 is the most significant bit
  localparam int          BO_IGNORE   = 4;
  localparam int          BO_SENSE    = 3;
  localparam int          BO_NO_DEC   = 2;
  localparam int          BO_ZERO     = 1;
  localparam int          BO_HINT     = 0;

  // ==========================================================================
  // Reset and arithmetic constants
  localparam logic [31:0] FLAGS_RST   = 32'h0000_0000;
  localparam logic [31:0] CTR_RST     = 32'h0000_0000;
  localparam logic [31:0] CTR_ONE     = 32'h0000_0001;
  localparam logic [31:0] CTR_ZERO    = 32'h0000_0000;
  localparam logic [4:0]  FIELD_RST   = 5'h00;
  localparam logic [5:0]  NUM_RST     = 6'h00;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    LOG_AND, LOG_OR, LOG_XOR, LOG_NAND, LOG_NOR, LOG_EQV, LOG_ANDC, LOG_ORC
  } flag_logic_op_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_HOLD
  } branch_state_t;

endpackage

// ===== hdl/flag_index_decode.sv
// Splits a flag index field into group, position and flag numbers
`timescale 1ns/1ps
module flag_index_decode (
  input  wire logic [4:0] flag_index_field_i,
  output logic      [2:0] group_o,
  output logic      [1:0] pos_o,
  output logic      [4:0] flat_o,
  output logic      [5:0] flag_num_o
);

  // ==========================================================================
  // Upper three bits pick the group, lower two the flag in it
  assign group_o    = flag_index_field_i[4:2];
  assign pos_o      = flag_index_field_i[1:0];
  assign flat_o     = 5'({group_o, 2'h0}) + 5'(pos_o);
  // Old code numbered flags from zero; the offset is added here
  assign flag_num_o = cond_flag_pkg::FLAG_BASE + {1'b0, flat_o};

endmodule

// ===== hdl/flag_compare.sv
// Signed or unsigned three-way compare of two words
`timescale 1ns/1ps
module flag_compare (
  input  wire logic [31:0] first_source_gpr_i,
  input  wire logic [31:0] other_operand_i,
  input  wire logic        signed_i,
  output logic             lt_o,
  output logic             gt_o,
  output logic             eq_o
);

  logic signed_lt;
  logic unsigned_lt;

  // ==========================================================================
  // Compare
  assign signed_lt   = $signed(first_source_gpr_i) < $signed(other_operand_i);
  assign unsigned_lt = first_source_gpr_i < other_operand_i;
  assign eq_o        = first_source_gpr_i == other_operand_i;
  assign lt_o        = signed_i ? signed_lt : unsigned_lt;
  assign gt_o        = !eq_o && !lt_o;

endmodule

// ===== test/branch_req_model.sv
// Branch unit model that issues branch requests and holds them until accepted
`timescale 1ns/1ps
module branch_req_model (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        req_i,
  input  wire logic [4:0]  idx_i,
  input  wire logic [4:0]  opt_i,
  input  wire logic [31:0] cnt_i,
  input  wire logic        busy_i,
  output logic             valid_o,
  output logic      [4:0]  idx_o,
  output logic      [4:0]  opt_o,
  output logic      [31:0] cnt_o
);
  // ====================
  // Request holding
  // Fields flip once released, so a late sample shows up as a wrong value
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      valid_o <= 1'b0;
      idx_o   <= 5'h00;
      opt_o   <= 5'h00;
      cnt_o   <= 32'h0;
    end
    else if (valid_o && !busy_i)
    begin
      valid_o <= 1'b0;
      idx_o   <= ~idx_o;
      opt_o   <= ~opt_o;
      cnt_o   <= ~cnt_o;
    end
    else if (req_i && !valid_o)
    begin
      valid_o <= 1'b1;
      idx_o   <= idx_i;
      opt_o   <= opt_i;
      cnt_o   <= cnt_i;
    end
  end
endmodule

// ===== test/test_cond_flag_bit_select.sv
// Self-checking bench of the condition flag select and update block
`timescale 1ns/1ps
module test_cond_flag_bit_select;
  logic        clk, rst, rv, sov, cv, csg, mv, fv, req, bv;
  logic        busy, done, tk, tf, we, hint;
  logic [2:0]  cgrp, fop;
  logic [4:0]  fa, fb, fd, bidx, bopt, ridx, ropt, o;
  logic [5:0]  tnum;
  logic [7:0]  mmask, pend;
  logic [31:0] rres, ca, cb, mdata, rcnt, bcnt, cfr, lco, fm, seed, a, r;
  logic [47:0] bq[$];
  logic [4:0]  opts[9] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h12, 5'h14};
  int          n_errors, check_count, n_done, nd;

  cond_flag_bit_select u_cond_flag_bit_select (
    .mclk_i(clk), .sys_rst_i(rst), .rec_valid_i(rv), .rec_result_i(rres),
    .fixed_point_exception_register_so_i(sov), .cmp_valid_i(cv), .flag_group_operand_i(cgrp),
    .first_source_gpr_i(ca), .cmp_operand_i(cb), .cmp_signed_i(csg), .mtf_valid_i(mv),
    .mtf_mask_i(mmask), .mtf_data_i(mdata), .flog_valid_i(fv), .flog_op_i(fop),
    .flog_src_a_i(fa), .flog_src_b_i(fb), .flog_dst_i(fd), .flag_pend_grp_i(pend),
    .branch_valid_i(bv), .flag_index_field_i(bidx), .branch_options_field_i(bopt),
    .loop_count_register_i(bcnt), .condition_flags_register_o(cfr), .branch_busy_o(busy),
    .branch_done_o(done), .branch_taken_o(tk), .branch_hint_o(hint), .tested_flag_o(tf),
    .tested_flag_num_o(tnum), .loop_count_we_o(we), .loop_count_o(lco));

  branch_req_model u_branch_req_model (
    .mclk_i(clk), .sys_rst_i(rst), .req_i(req), .idx_i(ridx), .opt_i(ropt), .cnt_i(rcnt),
    .busy_i(busy), .valid_o(bv), .idx_o(bidx), .opt_o(bopt), .cnt_o(bcnt));

  // ====================
  // Clock, checking and verdict
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Watches branch results mid-cycle, where the one-cycle done pulse has settled
  always @(negedge clk)
  begin
    if (done === 1'b1 && !rst)
    begin
      n_done++;
      if (bq.size() == 0)
        check(48'h1, 48'h0);
      else
        check(48'({tk, tf, tnum, we, lco, hint}), bq.pop_front());
    end
  end

  // ====================
  // Stimulus tasks
  task automatic mtf(input logic [7:0] m, input logic [31:0] d);
    @(negedge clk);
    mv = 1'b1;
    mmask = m;
    mdata = d;
    for (int g = 0; g < 8; g++)
      if (m[g]) fm[4*g+:4] = d[4*g+:4];
    @(negedge clk);
    mv = 1'b0;
    check(48'(cfr), 48'(fm));
  endtask

  task automatic rec(input logic [31:0] v, input logic so);
    @(negedge clk);
    rv = 1'b1;
    rres = v;
    sov = so;
    fm[3:0] = {so, v == 32'h0, !v[31] && v != 32'h0, v[31]};
    @(negedge clk);
    rv = 1'b0;
    check(48'(cfr), 48'(fm));
  endtask

  task automatic cmp(input logic [2:0] g, input logic [31:0] x, y, input logic s, so);
    @(negedge clk);
    cv = 1'b1;
    cgrp = g;
    ca = x;
    cb = y;
    csg = s;
    sov = so;
    fm[4*g+:4] = {so, x == y, s ? $signed(x) > $signed(y) : x > y,
                  s ? $signed(x) < $signed(y) : x < y};
    @(negedge clk);
    cv = 1'b0;
    check(48'(cfr), 48'(fm));
  endtask

  // All four writers in one cycle: record beats compare beats logical beats move
  task automatic all_writers();
    logic [31:0] q, d;
    logic        x, y;
    q = rnd();
    d = rnd();
    @(negedge clk);
    {mv, fv, cv, rv} = 4'hf;
    mmask = 8'hff;
    mdata = d;
    fop = 3'h2;
    fa = q[4:0];
    fb = q[9:5];
    fd = q[14:10];
    cgrp = q[17:15];
    ca = q;
    cb = d;
    csg = q[18];
    rres = d;
    sov = q[19];
    x = fm[q[4:0]];
    y = fm[q[9:5]];
    fm = d;
    fm[q[14:10]] = x ^ y;
    fm[4*q[17:15]+:4] = {q[19], q == d, csg ? $signed(q) > $signed(d) : q > d,
                         csg ? $signed(q) < $signed(d) : q < d};
    fm[3:0] = {q[19], d == 32'h0, !d[31] && d != 32'h0, d[31]};
    @(negedge clk);
    {mv, fv, cv, rv} = 4'h0;
    check(48'(cfr), 48'(fm));
  endtask

  task automatic flog(input logic [2:0] op);
    logic [31:0] q;
    logic        x, y;
    q = rnd();
    @(negedge clk);
    fv = 1'b1;
    fop = op;
    fa = q[4:0];
    fb = q[9:5];
    fd = q[14:10];
    x = fm[q[4:0]];
    y = fm[q[9:5]];
    case (op)
      3'h0: fm[q[14:10]] = x & y;
      3'h1: fm[q[14:10]] = x | y;
      3'h2: fm[q[14:10]] = x ^ y;
      3'h3: fm[q[14:10]] = ~(x & y);
      3'h4: fm[q[14:10]] = ~(x | y);
      3'h5: fm[q[14:10]] = ~(x ^ y);
      3'h6: fm[q[14:10]] = x & ~y;
      default: fm[q[14:10]] = x | ~y;
    endcase
    @(negedge clk);
    fv = 1'b0;
    check(48'(cfr), 48'(fm));
  endtask

  // Notes the expected outcome, then hands the request to the branch unit model
  task automatic branch(input logic [4:0] i, input logic [4:0] op, input logic [31:0] c,
                        input logic f);
    logic [31:0] nc;
    nc = op[2] ? c : c - 32'h1;
    bq.push_back(48'({(op[4] | f == op[3]) & (op[2] | (nc == 32'h0) == op[1]), f,
                      cond_flag_pkg::FLAG_BASE + {1'b0, i}, !op[2], nc, op[0]}));
    @(negedge clk);
    req = 1'b1;
    ridx = i;
    ropt = op;
    rcnt = c;
    @(negedge clk);
    req = 1'b0;
  endtask

  task automatic drain();
    for (int k = 0; k < 40 && bq.size() != 0; k++)
      @(negedge clk);
    check(48'(bq.size()), 48'h0);
  endtask

  // ====================
  // Main sequence
  initial
  begin
    {rv, sov, cv, csg, mv, fv, req, cgrp, fop, fa, fb, fd, ridx, ropt} = '0;
    {mmask, pend, rres, ca, cb, mdata, rcnt, fm} = '0;
    n_errors = 0;
    check_count = 0;
    n_done = 0;
    seed = 32'h0000_e02a; // 57386
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(48'({cfr, busy, done, tk, tf, tnum, we, hint}), 48'h0);
    $display("test reset done");
    rec(32'h0, 1'b1);
    rec(32'h8000_0000, 1'b0);
    rec(32'h1, 1'b0);
    for (int i = 0; i < 20; i++)
      rec(rnd(), i[0]);
    $display("test record form done");
    for (int i = 0; i < 40; i++)
    begin
      a = rnd();
      r = rnd();
      cmp(r[2:0], a, r[5] ? a : (r[6] ? ~a : rnd()), r[3], r[4]);
    end
    $display("test compare done");
    mtf(8'hff, rnd());
    mtf(8'h5a, rnd());
    for (int k = 0; k < 16; k++)
      flog(k[2:0]);
    repeat (8) all_writers();
    $display("test flag writes done");
    for (int i = 0; i < 64; i++)
    begin
      r = rnd();
      if (i % 8 == 0) mtf(8'hff, rnd());
      o = i < 32 ? opts[i % 9] | {4'h0, r[0]} : r[8:4];
      branch(i[4:0], o, i % 4 == 0 ? 32'h1 : {30'h0, r[2:1]}, fm[i[4:0]]);
      drain();
    end
    $display("test branch decode done");
    // Branch must wait while an older writer of its group is in flight
    nd = n_done;
    pend = 8'h20;
    branch(5'h16, 5'h0c, 32'h5, ~fm[22]);
    repeat (6) @(negedge clk);
    check(48'(n_done - nd), 48'h0);
    check({47'h0, busy}, 48'h1);
    mtf(8'h20, ~fm);
    pend = 8'h00;
    drain();
    $display("test pending writer done");
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
